// ==== rtc_pkg.sv ====
package rtc_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] CONFIG_OFFSET = 8'h00;
  localparam logic [7:0] VALUE_HIGH_OFFSET = 8'h04;
  localparam logic [7:0] VALUE_LOW_OFFSET = 8'h08;
  localparam logic [7:0] ALARM_CONFIG_OFFSET = 8'h0C;
  localparam logic [7:0] ALARM_HIGH_OFFSET = 8'h10;
  localparam logic [7:0] ALARM_LOW_OFFSET = 8'h14;
  localparam logic [7:0] UNLOCK_OFFSET = 8'h18;

  // Configuration register fields
  localparam int RUN_ENABLE_BIT = 7;
  localparam int WRITE_ENABLE_BIT = 5;
  localparam int SYNC_FLAG_BIT = 4;
  localparam int HALF_SECOND_BIT = 3;
  localparam int POINTER_LSB = 0;

  // Digit field masks
  localparam logic [7:0] HOUR_MASK = 8'h3F;
  localparam logic [7:0] MIN_SEC_MASK = 8'h7F;
  localparam logic [7:0] WEEKDAY_MASK = 8'h07;

  // Unlock sequence bytes
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;

  // Calendar reset values and limits, BCD
  localparam logic [7:0] FIRST_DAY = 8'h01;
  localparam logic [7:0] FIRST_MONTH = 8'h01;
  localparam logic [7:0] LAST_SECOND = 8'h59;
  localparam logic [7:0] LAST_HOUR = 8'h23;
  localparam logic [7:0] LAST_MONTH = 8'h12;
  localparam logic [7:0] LAST_YEAR = 8'h99;
  localparam logic [7:0] LAST_WEEKDAY = 8'h06;

  // Timing
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int HALF_SECOND_NS = 500000000;
  localparam int HALF_SECOND_CYCLES = HALF_SECOND_NS / CLOCK_PERIOD_NS;
  localparam int SYNC_LEAD_NS = 320;
  localparam int SYNC_LEAD_CYCLES = (SYNC_LEAD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int PRESC_WIDTH = 26;

  // AHB transfer type bit marking an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    UNLOCK_IDLE = 2'b00,
    UNLOCK_GOT_FIRST = 2'b01,
    UNLOCK_ARMED = 2'b10
  } unlock_state_t;

endpackage

// ==== rtc_calendar_register_access.sv ====
// Notes on behaviour
// - Alarm hours: tens digit bits 5-4 (0-2), ones bits 3-0 (0-9).
// - Alarm hours write accepted only while timer write enable is set.
// - Alarm minutes: tens bits 6-4 (0-5), ones bits 3-0, bit 7 reads zero.
// - Alarm seconds: tens bits 6-4 (0-5), ones bits 3-0, bit 7 reads zero.
// - Years 2000-2099; every year divisible by four is leap.
// - February has 29 days in leap years, 28 otherwise.
// - All time registers of seconds and above writable; counting resumes from them.
// - Clock runs while config bit 7 set, also during software adjustment.
// - Writing minutes or seconds clears the prescaler; writing seconds also clears the half-second bit.
// - Timer register writes take effect in the write's own cycle.
// - Half-second field is read-only, toggled each half second and cleared by writing seconds.
// - Sync flag reads zero only while access is safe from rollover.
// - Timer register writes blocked unless config bit 5 is set.
// - Write enable settable only right after 0x55 then 0xAA to unlock register.
// - Config bits 1:0 select the register pair in the value windows.
// - High window access decrements the pointer, stopping at 00.
// - Pointer 00 shows minutes/seconds; 01 weekday/hours.
// - Alarm windows use their own pointer, decrementing to 00 (minutes/seconds).
//
// Our own choices: the address map and the AHB-Lite register port.
module rtc_calendar_register_access #(
  parameter int unsigned HALF_SECOND_CYCLES = rtc_pkg::HALF_SECOND_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  typedef struct packed {
    logic runEnable;
    logic writeEnable;
    logic [1:0] ptr;
    logic [1:0] alarmPtr;
    rtc_pkg::unlock_state_t unlock;
    logic [rtc_pkg::PRESC_WIDTH-1:0] prescCount;
    logic halfSec;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] weekday;
    logic [7:0] day;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] alarmHour;
    logic [7:0] alarmMin;
    logic [7:0] alarmSec;
    logic [7:0] alarmWeekday;
    logic dpValid;
    logic dpWrite;
    logic [7:0] dpAddr;
    logic readyOut;
    logic [31:0] readData;
    logic resp;
  } state_t;

  state_t s_q;
  state_t s_d;

  // BCD increment with wrap to first value after last
  function automatic logic [7:0] bcdNext(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
    logic [7:0] r;
    r = v;
    if (v == last) begin
      r = first;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // Leap test on BCD year: divisible by four
  function automatic logic isLeap(input logic [7:0] y);
    logic r;
    r = 1'b0;
    if (!y[4]) begin
      r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end else begin
      r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
    return r;
  endfunction

  // Last day of month in BCD
  function automatic logic [7:0] lastDay(input logic [7:0] m, input logic [7:0] y);
    logic [7:0] r;
    r = 8'h31;
    case (m)
      8'h02: r = isLeap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
      default: r = 8'h31;
    endcase
    return r;
  endfunction

  // Pointer decrement, holding at zero
  function automatic logic [1:0] ptrDown(input logic [1:0] p);
    return (p == 2'b00) ? 2'b00 : p - 2'b01;
  endfunction

  logic syncFlag;
  logic halfTick;
  logic secondTick;
  logic [7:0] configRead;
  logic [7:0] valueHigh;
  logic [7:0] valueLow;
  logic [7:0] alarmHigh;
  logic [7:0] alarmLow;
  logic [7:0] wbyte;
  logic timerWrite;

  always_comb begin
    halfTick = s_q.runEnable && (s_q.prescCount == rtc_pkg::PRESC_WIDTH'(HALF_SECOND_CYCLES - 1));
    secondTick = halfTick && s_q.halfSec;
    syncFlag = s_q.runEnable && s_q.halfSec &&
      (s_q.prescCount >= rtc_pkg::PRESC_WIDTH'(HALF_SECOND_CYCLES - rtc_pkg::SYNC_LEAD_CYCLES));
    configRead = 8'h00;
    configRead[rtc_pkg::RUN_ENABLE_BIT] = s_q.runEnable;
    configRead[rtc_pkg::WRITE_ENABLE_BIT] = s_q.writeEnable;
    configRead[rtc_pkg::SYNC_FLAG_BIT] = syncFlag;
    configRead[rtc_pkg::HALF_SECOND_BIT] = s_q.halfSec;
    configRead[rtc_pkg::POINTER_LSB +: 2] = s_q.ptr;
    case (s_q.ptr)
      2'b00: begin
        valueHigh = s_q.min;
        valueLow = s_q.sec;
      end
      2'b01: begin
        valueHigh = s_q.weekday;
        valueLow = s_q.hour;
      end
      2'b10: begin
        valueHigh = s_q.month;
        valueLow = s_q.day;
      end
      default: begin
        valueHigh = 8'h00;
        valueLow = s_q.year;
      end
    endcase
    case (s_q.alarmPtr)
      2'b00: begin
        alarmHigh = s_q.alarmMin;
        alarmLow = s_q.alarmSec;
      end
      2'b01: begin
        alarmHigh = s_q.alarmWeekday;
        alarmLow = s_q.alarmHour;
      end
      default: begin
        alarmHigh = 8'h00;
        alarmLow = 8'h00;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    wbyte = hwdata[7:0];
    timerWrite = s_q.dpValid && s_q.dpWrite && s_q.writeEnable;
    s_d.resp = rtc_pkg::HRESP_OKAY;

    // Free-running calendar chain
    if (s_q.runEnable) begin
      s_d.prescCount = halfTick ? '0 : s_q.prescCount + 1'b1;
      if (halfTick) begin
        s_d.halfSec = ~s_q.halfSec;
      end
    end
    if (secondTick) begin
      s_d.sec = bcdNext(s_q.sec, rtc_pkg::LAST_SECOND, 8'h00);
      if (s_q.sec == rtc_pkg::LAST_SECOND) begin
        s_d.min = bcdNext(s_q.min, rtc_pkg::LAST_SECOND, 8'h00);
        if (s_q.min == rtc_pkg::LAST_SECOND) begin
          s_d.hour = bcdNext(s_q.hour, rtc_pkg::LAST_HOUR, 8'h00);
          if (s_q.hour == rtc_pkg::LAST_HOUR) begin
            s_d.weekday = bcdNext(s_q.weekday, rtc_pkg::LAST_WEEKDAY, 8'h00);
            s_d.day = bcdNext(s_q.day, lastDay(s_q.month, s_q.year), rtc_pkg::FIRST_DAY);
            if (s_q.day == lastDay(s_q.month, s_q.year)) begin
              s_d.month = bcdNext(s_q.month, rtc_pkg::LAST_MONTH, rtc_pkg::FIRST_MONTH);
              if (s_q.month == rtc_pkg::LAST_MONTH) begin
                s_d.year = bcdNext(s_q.year, rtc_pkg::LAST_YEAR, 8'h00);
              end
            end
          end
        end
      end
    end

    // Bus address phase capture
    if (hready) begin
      s_d.dpValid = hsel && htrans[rtc_pkg::HTRANS_ACTIVE_BIT];
      s_d.dpWrite = hwrite;
      s_d.dpAddr = haddr[7:0];
      if (hsel && htrans[rtc_pkg::HTRANS_ACTIVE_BIT] && !hwrite) begin
        s_d.readyOut = 1'b0;
      end
    end

    // Any completed transfer closes the unlock window unless it advances it
    if (s_q.dpValid && (s_q.dpWrite || !s_q.readyOut)) begin
      s_d.unlock = rtc_pkg::UNLOCK_IDLE;
    end

    // Write data phase, applied on this edge
    if (s_q.dpValid && s_q.dpWrite) begin
      case (s_q.dpAddr)
        rtc_pkg::CONFIG_OFFSET: begin
          s_d.runEnable = wbyte[rtc_pkg::RUN_ENABLE_BIT];
          s_d.ptr = wbyte[rtc_pkg::POINTER_LSB +: 2];
          if (!wbyte[rtc_pkg::WRITE_ENABLE_BIT]) begin
            s_d.writeEnable = 1'b0;
          end else if (s_q.unlock == rtc_pkg::UNLOCK_ARMED) begin
            s_d.writeEnable = 1'b1;
          end
        end
        rtc_pkg::UNLOCK_OFFSET: begin
          if (wbyte == rtc_pkg::UNLOCK_FIRST) begin
            s_d.unlock = rtc_pkg::UNLOCK_GOT_FIRST;
          end else if (wbyte == rtc_pkg::UNLOCK_SECOND && s_q.unlock == rtc_pkg::UNLOCK_GOT_FIRST) begin
            s_d.unlock = rtc_pkg::UNLOCK_ARMED;
          end
        end
        rtc_pkg::VALUE_HIGH_OFFSET: begin
          s_d.ptr = ptrDown(s_q.ptr);
          if (timerWrite) begin
            case (s_q.ptr)
              2'b00: begin
                s_d.min = wbyte & rtc_pkg::MIN_SEC_MASK;
                s_d.prescCount = '0;
              end
              2'b01: s_d.weekday = wbyte & rtc_pkg::WEEKDAY_MASK;
              2'b10: s_d.month = wbyte;
              default: s_d.month = s_d.month;
            endcase
          end
        end
        rtc_pkg::VALUE_LOW_OFFSET: begin
          if (timerWrite) begin
            case (s_q.ptr)
              2'b00: begin
                s_d.sec = wbyte & rtc_pkg::MIN_SEC_MASK;
                s_d.prescCount = '0;
                s_d.halfSec = 1'b0;
              end
              2'b01: s_d.hour = wbyte & rtc_pkg::HOUR_MASK;
              2'b10: s_d.day = wbyte;
              default: s_d.year = wbyte;
            endcase
          end
        end
        rtc_pkg::ALARM_CONFIG_OFFSET: begin
          s_d.alarmPtr = wbyte[1:0];
        end
        rtc_pkg::ALARM_HIGH_OFFSET: begin
          s_d.alarmPtr = ptrDown(s_q.alarmPtr);
          if (timerWrite) begin
            case (s_q.alarmPtr)
              2'b00: s_d.alarmMin = wbyte & rtc_pkg::MIN_SEC_MASK;
              2'b01: s_d.alarmWeekday = wbyte & rtc_pkg::WEEKDAY_MASK;
              default: s_d.alarmMin = s_d.alarmMin;
            endcase
          end
        end
        rtc_pkg::ALARM_LOW_OFFSET: begin
          if (timerWrite) begin
            case (s_q.alarmPtr)
              2'b00: s_d.alarmSec = wbyte & rtc_pkg::MIN_SEC_MASK;
              2'b01: s_d.alarmHour = wbyte & rtc_pkg::HOUR_MASK;
              default: s_d.alarmSec = s_d.alarmSec;
            endcase
          end
        end
        default: s_d.dpValid = s_d.dpValid;
      endcase
    end

    // Read data phase, one wait state
    if (s_q.dpValid && !s_q.dpWrite && !s_q.readyOut) begin
      s_d.readyOut = 1'b1;
      s_d.readData = 32'h0000_0000;
      case (s_q.dpAddr)
        rtc_pkg::CONFIG_OFFSET: s_d.readData[7:0] = configRead;
        rtc_pkg::VALUE_HIGH_OFFSET: begin
          s_d.readData[7:0] = valueHigh;
          s_d.ptr = ptrDown(s_q.ptr);
        end
        rtc_pkg::VALUE_LOW_OFFSET: s_d.readData[7:0] = valueLow;
        rtc_pkg::ALARM_CONFIG_OFFSET: s_d.readData[7:0] = {6'h00, s_q.alarmPtr};
        rtc_pkg::ALARM_HIGH_OFFSET: begin
          s_d.readData[7:0] = alarmHigh;
          s_d.alarmPtr = ptrDown(s_q.alarmPtr);
        end
        rtc_pkg::ALARM_LOW_OFFSET: s_d.readData[7:0] = alarmLow;
        default: s_d.readData = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.unlock <= rtc_pkg::UNLOCK_IDLE;
      s_q.day <= rtc_pkg::FIRST_DAY;
      s_q.month <= rtc_pkg::FIRST_MONTH;
      s_q.readyOut <= 1'b1;
      s_q.resp <= rtc_pkg::HRESP_OKAY;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.readData;
  assign hreadyout = s_q.readyOut;
  assign hresp = s_q.resp;

endmodule // rtc_calendar_register_access

// ==== rtc_calendar_asserts.sv ====
module rtc_calendar_asserts (
  input wire logic clock,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  logic taken;
  assign taken = hready && hsel && htrans[1];
  read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_fast_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  resp_okay_a: assert property (hresp == rtc_pkg::HRESP_OKAY)
    else $error("response not okay");
  alarm_min_top_a: assert property (
    taken && !hwrite && haddr[7:0] == rtc_pkg::ALARM_HIGH_OFFSET |=> ##1 !hrdata[7])
    else $error("alarm high top bit set");
  alarm_sec_top_a: assert property (
    taken && !hwrite && haddr[7:0] == rtc_pkg::ALARM_LOW_OFFSET |=> ##1 !hrdata[7])
    else $error("alarm low top bit set");
  unlock_reads_a: assert property (
    taken && !hwrite && haddr[7:0] == rtc_pkg::UNLOCK_OFFSET |=> ##1 hrdata == 32'h0)
    else $error("unlock register readable");
  upper_zero_a: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  hold_data_a: assert property (taken && hwrite |=> ##1 $stable(hrdata))
    else $error("read data moved on write");
endmodule // rtc_calendar_asserts

// ==== tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, resetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] rv;
  int errors, n_tests;
  logic [7:0] yr [2] = '{8'h24, 8'h23};
  logic [7:0] dy [2] = '{8'h29, 8'h01};
  logic [7:0] mo [2] = '{8'h02, 8'h03};
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

  rtc_calendar_register_access #(.HALF_SECOND_CYCLES(50)) dut_u (
    .clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clock); while (hreadyout !== 1'b1);
    rv = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(rv, e)
    `CHK(hresp, rtc_pkg::HRESP_OKAY)
  endtask

  task automatic unlock;
    wr(rtc_pkg::UNLOCK_OFFSET, rtc_pkg::UNLOCK_FIRST);
    wr(rtc_pkg::UNLOCK_OFFSET, rtc_pkg::UNLOCK_SECOND);
  endtask

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    report_and_stop();
  end

  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    errors = 0;
    n_tests = 0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge clock);
    rd(rtc_pkg::CONFIG_OFFSET, 8'h00);
    rd(rtc_pkg::VALUE_LOW_OFFSET, 8'h00);
    wr(8'h1C, 8'hFF);
    rd(8'h1C, 8'h00);
    rd(rtc_pkg::UNLOCK_OFFSET, 8'h00);
    $display("Reset and map test done");
    wr(rtc_pkg::VALUE_LOW_OFFSET, 8'h45);
    rd(rtc_pkg::VALUE_LOW_OFFSET, 8'h00);
    wr(rtc_pkg::CONFIG_OFFSET, 8'h20);
    rd(rtc_pkg::CONFIG_OFFSET, 8'h00);
    wr(rtc_pkg::UNLOCK_OFFSET, rtc_pkg::UNLOCK_FIRST);
    rd(rtc_pkg::CONFIG_OFFSET, 8'h00);
    wr(rtc_pkg::UNLOCK_OFFSET, rtc_pkg::UNLOCK_SECOND);
    wr(rtc_pkg::CONFIG_OFFSET, 8'h20);
    rd(rtc_pkg::CONFIG_OFFSET, 8'h00);
    unlock();
    wr(rtc_pkg::CONFIG_OFFSET, 8'h20);
    rd(rtc_pkg::CONFIG_OFFSET, 8'h20);
    $display("Write lock test done");
    wr(rtc_pkg::ALARM_CONFIG_OFFSET, 8'h01);
    wr(rtc_pkg::ALARM_LOW_OFFSET, 8'hE3);
    wr(rtc_pkg::ALARM_HIGH_OFFSET, 8'hFE);
    wr(rtc_pkg::ALARM_LOW_OFFSET, 8'hD9);
    wr(rtc_pkg::ALARM_HIGH_OFFSET, 8'hFF);
    rd(rtc_pkg::ALARM_LOW_OFFSET, 8'h59);
    rd(rtc_pkg::ALARM_HIGH_OFFSET, 8'h7F);
    rd(rtc_pkg::ALARM_LOW_OFFSET, 8'h59);
    wr(rtc_pkg::ALARM_CONFIG_OFFSET, 8'h01);
    rd(rtc_pkg::ALARM_LOW_OFFSET, 8'h23);
    rd(rtc_pkg::ALARM_HIGH_OFFSET, 8'h06);
    wr(rtc_pkg::CONFIG_OFFSET, 8'h00);
    wr(rtc_pkg::ALARM_CONFIG_OFFSET, 8'h01);
    wr(rtc_pkg::ALARM_LOW_OFFSET, 8'h11);
    rd(rtc_pkg::ALARM_LOW_OFFSET, 8'h23);
    $display("Alarm test done");
    for (int i = 0; i < 2; i++) begin
      unlock();
      wr(rtc_pkg::CONFIG_OFFSET, 8'h23);
      wr(rtc_pkg::VALUE_LOW_OFFSET, yr[i]);
      wr(rtc_pkg::VALUE_HIGH_OFFSET, 8'h00);
      wr(rtc_pkg::VALUE_LOW_OFFSET, 8'h28);
      wr(rtc_pkg::VALUE_HIGH_OFFSET, 8'h02);
      wr(rtc_pkg::VALUE_LOW_OFFSET, 8'h23);
      wr(rtc_pkg::VALUE_HIGH_OFFSET, 8'h03);
      wr(rtc_pkg::VALUE_LOW_OFFSET, 8'h59);
      wr(rtc_pkg::VALUE_HIGH_OFFSET, 8'h59);
      wr(rtc_pkg::CONFIG_OFFSET, 8'h80);
      rd(rtc_pkg::CONFIG_OFFSET, 8'h80);
      repeat (70) @(posedge clock);
      rd(rtc_pkg::CONFIG_OFFSET, 8'h98);
      repeat (40) @(posedge clock);
      wr(rtc_pkg::CONFIG_OFFSET, 8'h82);
      rd(rtc_pkg::VALUE_LOW_OFFSET, dy[i]);
      rd(rtc_pkg::VALUE_LOW_OFFSET, dy[i]);
      rd(rtc_pkg::VALUE_HIGH_OFFSET, mo[i]);
      rd(rtc_pkg::VALUE_LOW_OFFSET, 8'h00);
      rd(rtc_pkg::VALUE_HIGH_OFFSET, 8'h04);
      rd(rtc_pkg::VALUE_LOW_OFFSET, 8'h00);
      rd(rtc_pkg::VALUE_HIGH_OFFSET, 8'h00);
      rd(rtc_pkg::VALUE_HIGH_OFFSET, 8'h00);
      wr(rtc_pkg::CONFIG_OFFSET, 8'h83);
      rd(rtc_pkg::VALUE_LOW_OFFSET, yr[i]);
      rd(rtc_pkg::VALUE_HIGH_OFFSET, 8'h00);
      $display("Calendar test %0d done", i);
    end
    report_and_stop();
  end
endmodule // tb

bind rtc_calendar_register_access rtc_calendar_asserts chk_u (
  .clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp));
